// ==== rtl/pmsc_map.svh ====
// Constants for the mode and status controller: timing counts, counter width, image size, block numbers and safe output level
`ifndef PMSC_MAP_SVH
`define PMSC_MAP_SVH
`define PMSC_CLK_MHZ            200
`define PMSC_DEBOUNCE_US        1000
`define PMSC_DEBOUNCE_CYC       (`PMSC_DEBOUNCE_US * `PMSC_CLK_MHZ)
`define PMSC_LAMP_TEST_MS       500
`define PMSC_LAMP_TEST_CYC      (`PMSC_LAMP_TEST_MS * 1000 * `PMSC_CLK_MHZ)
`define PMSC_FAST_HALF_MS       100
`define PMSC_FAST_HALF_CYC      (`PMSC_FAST_HALF_MS * 1000 * `PMSC_CLK_MHZ)
`define PMSC_SLOW_HALF_MS       500
`define PMSC_SLOW_HALF_CYC      (`PMSC_SLOW_HALF_MS * 1000 * `PMSC_CLK_MHZ)
`define PMSC_CNT_W              32
`define PMSC_IMAGE_LAST_BYTE    127
`define PMSC_STARTUP_BLOCK      20
`define PMSC_STOP_BLOCK         39
`define PMSC_SAFE_OUT           1'b0
`endif

// ==== rtl/pmsc_pkg.sv ====
// Types for the mode and status controller
package pmsc_pkg;
    typedef enum logic [1:0] {
        PMSC_MC_MID,
        PMSC_MC_UP,
        PMSC_MC_DOWN
    } pmsc_mc_t;

    typedef enum logic [2:0] {
        PMSC_ST_LAMP,
        PMSC_ST_INIT,
        PMSC_ST_RUN,
        PMSC_ST_SOFT,
        PMSC_ST_HARD
    } pmsc_state_t;

    typedef enum logic [1:0] {
        PMSC_GO_NONE,
        PMSC_GO_OVERALL,
        PMSC_GO_RESET,
        PMSC_GO_RESTART
    } pmsc_start_t;
endpackage : pmsc_pkg

// ==== rtl/pmsc_ctrl.sv ====
// Operating-state controller and front-panel indicator logic
// Summary of operation
// - Mode switch at run: execute program cyclically, run lamp lit.
// - Mode switch run to stop: enter stop state, stop lamp lit.
// - Overall reset erases and reinitializes all module and submodule RAM.
// - Reset clears flags, timers, counters, image; calls startup block; restarts program.
// - Restart resumes program where interrupted, keeping all retained data.
// - Soft stop may run stop-time block but digital outputs stay inhibited.
// - Hard stop runs nothing and exits only through power cycling.
// - In run: run lamp on, stop and hard-stop lamps off.
// - After power-up all three status lamps light briefly.
// - Initial start or program check: all three status lamps off.
// - Soft stop lamp steady, rapid flashing when overall reset is requested.
// - Soft stop caused by an error: stop lamp flashes slowly.
// - Hard stop: only the hard-stop lamp lit; code also lights the output-inhibit lamp.
// - Light ack-timeout lamp when a registered or accessed module fails to acknowledge.
// - Light ack-timeout lamp when a user memory access times out.
// - Light addressing-error lamp on reference to an unregistered image address.
// - Cycle monitor expiry interrupts cyclic processing, lights cycle-overrun lamp.
// - Output inhibit lights its lamp and forces digital outputs to zero.
// - Power-up in stop: stop lamp flashes rapidly, output-inhibit lamp lit.
// - Overall reset switch held with stop-to-run performs it; stop lamp then steady, or flashing slowly if an error stop is still pending.
// - Reset switch held with stop-to-run goes to run unless overall reset is requested; stop and inhibit lamps off.
// - Midpoint switch with stop-to-run restarts unless overall reset is requested; run lamp on, others off; code keeps sticky fault lamps lit until FAULT_CLEAR.
`include "pmsc_map.svh"
module pmsc_ctrl #(
    parameter int unsigned DEBOUNCE_CYC  = `PMSC_DEBOUNCE_CYC,
    parameter int unsigned LAMP_TEST_CYC = `PMSC_LAMP_TEST_CYC,
    parameter int unsigned FAST_HALF_CYC = `PMSC_FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF_CYC = `PMSC_SLOW_HALF_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        CLK_EN,
    input  wire logic        MODE_RUN_SW,
    input  wire logic        MC_UP_SW,
    input  wire logic        MC_DOWN_SW,
    input  wire logic        OS_OVERALL_REQ,
    input  wire logic        ERROR_STOP,
    input  wire logic        HARD_FAULT,
    input  wire logic        INIT_DONE,
    input  wire logic        MEM_CLEAR_DONE,
    input  wire logic        MODULE_ACK_TIMEOUT,
    input  wire logic        USER_MEM_TIMEOUT,
    input  wire logic        ADDRESSING_ERROR,
    input  wire logic        CYCLE_MONITOR_EXPIRED,
    input  wire logic        FAULT_CLEAR,
    input  wire logic [7:0]  DIGITAL_OUT_IN,
    output logic [7:0]       DIGITAL_OUT,
    output logic             PROGRAM_RUN,
    output logic             STOP_BLOCK_ENABLE,
    output logic             RAM_ERASE_REQ,
    output logic             IMAGE_CLEAR_REQ,
    output logic             STARTUP_BLOCK_CALL,
    output logic             RESUME_REQ,
    output pmsc_pkg::pmsc_state_t STATE,
    output logic             RUN_INDICATOR,
    output logic             STOP_INDICATOR,
    output logic             HARD_STOP_INDICATOR,
    output logic             ACK_TIMEOUT_INDICATOR,
    output logic             ADDRESSING_ERROR_INDICATOR,
    output logic             CYCLE_OVERRUN_INDICATOR,
    output logic             OUTPUT_INHIBIT_INDICATOR
);
    import pmsc_pkg::*;

    // Switch synchronisers and debounce
    logic [2:0]  sw_raw;
    logic [2:0]  sync1_r, sync2_r, sync3_r;
    logic [2:0]  sw_db_r, sw_db_nxt;
    logic [2:0]  sw_prev_r;
    logic [31:0] db_cnt_r [3];
    logic [31:0] db_cnt_nxt [3];

    assign sw_raw = {MC_DOWN_SW, MC_UP_SW, MODE_RUN_SW};

    // A count restarts whenever the last two sync stages disagree or the level is already taken
    generate
        for (genvar i = 0; i < 3; i++) begin : g_db
            always_comb begin
                db_cnt_nxt[i] = db_cnt_r[i];
                sw_db_nxt[i]  = sw_db_r[i];
                if (sync2_r[i] != sync3_r[i] || sync3_r[i] == sw_db_r[i]) begin
                    db_cnt_nxt[i] = 32'h0;
                end else if (db_cnt_r[i] >= DEBOUNCE_CYC - 1) begin
                    db_cnt_nxt[i] = 32'h0;
                    sw_db_nxt[i]  = sync3_r[i];
                end else begin
                    db_cnt_nxt[i] = db_cnt_r[i] + 32'h1;
                end
            end
            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    db_cnt_r[i] <= 32'h0;
                end else if (CLK_EN) begin
                    db_cnt_r[i] <= db_cnt_nxt[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sync1_r   <= 3'h0;
            sync2_r   <= 3'h0;
            sync3_r   <= 3'h0;
            sw_db_r   <= 3'h0;
            sw_prev_r <= 3'h0;
        end else if (CLK_EN) begin
            sync1_r   <= sw_raw;
            sync2_r   <= sync1_r;
            sync3_r   <= sync2_r;
            sw_db_r   <= sw_db_nxt;
            sw_prev_r <= sw_db_r;
        end
    end

    logic     mode_run;
    logic     to_run;
    logic     to_stop;
    pmsc_mc_t mc_pos;

    assign mode_run = sw_db_r[0];
    assign to_run   = sw_db_r[0] & ~sw_prev_r[0];
    assign to_stop  = ~sw_db_r[0] & sw_prev_r[0];
    assign mc_pos   = sw_db_r[2] ? PMSC_MC_DOWN : (sw_db_r[1] ? PMSC_MC_UP : PMSC_MC_MID);

    // Operating state machine
    pmsc_state_t state_r, state_nxt;
    pmsc_start_t start_r, start_nxt;
    logic [31:0] lamp_cnt_r, lamp_cnt_nxt;
    logic        ovr_req_r, ovr_req_nxt;
    logic        err_stop_r, err_stop_nxt;
    logic        inhibit_r, inhibit_nxt;

    always_comb begin
        state_nxt    = state_r;
        start_nxt    = PMSC_GO_NONE;
        lamp_cnt_nxt = lamp_cnt_r;
        // Overall-reset request is sticky; a new request beats a clear in the same cycle
        ovr_req_nxt  = ovr_req_r | OS_OVERALL_REQ;
        err_stop_nxt = err_stop_r;
        inhibit_nxt  = inhibit_r;
        unique case (state_r)
            PMSC_ST_LAMP: begin
                inhibit_nxt = 1'b1;
                if (lamp_cnt_r >= LAMP_TEST_CYC - 1) begin
                    state_nxt   = PMSC_ST_INIT;
                    lamp_cnt_nxt = 32'h0;
                end else begin
                    lamp_cnt_nxt = lamp_cnt_r + 32'h1;
                end
            end
            PMSC_ST_INIT: begin
                if (INIT_DONE) begin
                    state_nxt = PMSC_ST_SOFT;
                    if (!mode_run) begin
                        ovr_req_nxt = 1'b1;
                    end
                end
            end
            PMSC_ST_RUN: begin
                inhibit_nxt = 1'b0;
                if (to_stop) begin
                    state_nxt   = PMSC_ST_SOFT;
                    inhibit_nxt = 1'b1;
                end else if (ERROR_STOP || CYCLE_MONITOR_EXPIRED) begin
                    state_nxt    = PMSC_ST_SOFT;
                    err_stop_nxt = 1'b1;
                    inhibit_nxt  = 1'b1;
                end
            end
            PMSC_ST_SOFT: begin
                inhibit_nxt = 1'b1;
                if (to_run) begin
                    unique case (mc_pos)
                        PMSC_MC_DOWN: begin
                            start_nxt   = PMSC_GO_OVERALL;
                            ovr_req_nxt = OS_OVERALL_REQ;
                        end
                        PMSC_MC_UP: begin
                            if (!ovr_req_r) begin
                                start_nxt    = PMSC_GO_RESET;
                                state_nxt    = PMSC_ST_RUN;
                                err_stop_nxt = 1'b0;
                                inhibit_nxt  = 1'b0;
                            end
                        end
                        PMSC_MC_MID: begin
                            if (!ovr_req_r) begin
                                start_nxt    = PMSC_GO_RESTART;
                                state_nxt    = PMSC_ST_RUN;
                                err_stop_nxt = 1'b0;
                                inhibit_nxt  = 1'b0;
                            end
                        end
                    endcase
                end
            end
            PMSC_ST_HARD: begin
                inhibit_nxt = 1'b1;
            end
        endcase
        // A hard fault overrides every other transition once lamp test is over
        // Only RST leaves hard stop, standing in for a power cycle
        if (HARD_FAULT && state_r != PMSC_ST_LAMP) begin
            state_nxt   = PMSC_ST_HARD;
            start_nxt   = PMSC_GO_NONE;
            inhibit_nxt = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_r    <= PMSC_ST_LAMP;
            start_r    <= PMSC_GO_NONE;
            lamp_cnt_r <= 32'h0;
            ovr_req_r  <= 1'b0;
            err_stop_r <= 1'b0;
            inhibit_r  <= 1'b1;
        end else if (CLK_EN) begin
            state_r    <= state_nxt;
            start_r    <= start_nxt;
            lamp_cnt_r <= lamp_cnt_nxt;
            ovr_req_r  <= ovr_req_nxt;
            err_stop_r <= err_stop_nxt;
            inhibit_r  <= inhibit_nxt;
        end
    end

    // Flash dividers
    logic [31:0] fast_cnt_r, fast_cnt_nxt;
    logic [31:0] slow_cnt_r, slow_cnt_nxt;
    logic        fast_ph_r, fast_ph_nxt;
    logic        slow_ph_r, slow_ph_nxt;

    always_comb begin
        fast_cnt_nxt = fast_cnt_r + 32'h1;
        fast_ph_nxt  = fast_ph_r;
        slow_cnt_nxt = slow_cnt_r + 32'h1;
        slow_ph_nxt  = slow_ph_r;
        if (fast_cnt_r >= FAST_HALF_CYC - 1) begin
            fast_cnt_nxt = 32'h0;
            fast_ph_nxt  = ~fast_ph_r;
        end
        if (slow_cnt_r >= SLOW_HALF_CYC - 1) begin
            slow_cnt_nxt = 32'h0;
            slow_ph_nxt  = ~slow_ph_r;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            fast_cnt_r <= 32'h0;
            slow_cnt_r <= 32'h0;
            fast_ph_r  <= 1'b0;
            slow_ph_r  <= 1'b0;
        end else if (CLK_EN) begin
            fast_cnt_r <= fast_cnt_nxt;
            slow_cnt_r <= slow_cnt_nxt;
            fast_ph_r  <= fast_ph_nxt;
            slow_ph_r  <= slow_ph_nxt;
        end
    end

    // Sticky fault lamps and registered outputs
    logic       ack_r, ack_nxt;
    logic       adf_r, adf_nxt;
    logic       cyc_r, cyc_nxt;
    logic       run_l, stop_l, hard_l;
    logic [7:0] dout_nxt;

    always_comb begin
        ack_nxt = (ack_r & ~FAULT_CLEAR) | MODULE_ACK_TIMEOUT | USER_MEM_TIMEOUT;
        adf_nxt = (adf_r & ~FAULT_CLEAR) | ADDRESSING_ERROR;
        cyc_nxt = (cyc_r & ~FAULT_CLEAR) | (CYCLE_MONITOR_EXPIRED & (state_r == PMSC_ST_RUN));
        run_l  = 1'b0;
        stop_l = 1'b0;
        hard_l = 1'b0;
        unique case (state_nxt)
            PMSC_ST_LAMP: begin
                run_l  = 1'b1;
                stop_l = 1'b1;
                hard_l = 1'b1;
            end
            PMSC_ST_INIT: begin
                run_l = 1'b0;
            end
            PMSC_ST_RUN: begin
                run_l = 1'b1;
            end
            PMSC_ST_SOFT: begin
                if (ovr_req_nxt) begin
                    stop_l = fast_ph_nxt;
                end else if (err_stop_nxt) begin
                    stop_l = slow_ph_nxt;
                end else begin
                    stop_l = 1'b1;
                end
            end
            PMSC_ST_HARD: begin
                hard_l = 1'b1;
            end
        endcase
        dout_nxt = inhibit_nxt ? {8{`PMSC_SAFE_OUT}} : DIGITAL_OUT_IN;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ack_r                      <= 1'b0;
            adf_r                      <= 1'b0;
            cyc_r                      <= 1'b0;
            RUN_INDICATOR              <= 1'b0;
            STOP_INDICATOR             <= 1'b0;
            HARD_STOP_INDICATOR        <= 1'b0;
            OUTPUT_INHIBIT_INDICATOR   <= 1'b1;
            DIGITAL_OUT                <= 8'h00;
        end else if (CLK_EN) begin
            ack_r                      <= ack_nxt;
            adf_r                      <= adf_nxt;
            cyc_r                      <= cyc_nxt;
            RUN_INDICATOR              <= run_l;
            STOP_INDICATOR             <= stop_l;
            HARD_STOP_INDICATOR        <= hard_l;
            OUTPUT_INHIBIT_INDICATOR   <= inhibit_nxt;
            DIGITAL_OUT                <= dout_nxt;
        end
    end

    assign ACK_TIMEOUT_INDICATOR      = ack_r;
    assign ADDRESSING_ERROR_INDICATOR = adf_r;
    assign CYCLE_OVERRUN_INDICATOR    = cyc_r;
    assign STATE                      = state_r;
    assign PROGRAM_RUN                = (state_r == PMSC_ST_RUN);
    assign STOP_BLOCK_ENABLE          = (state_r == PMSC_ST_SOFT);
    assign RAM_ERASE_REQ              = (start_r == PMSC_GO_OVERALL);
    assign IMAGE_CLEAR_REQ            = (start_r == PMSC_GO_RESET);
    assign STARTUP_BLOCK_CALL         = (start_r == PMSC_GO_RESET);
    assign RESUME_REQ                 = (start_r == PMSC_GO_RESTART);
endmodule : pmsc_ctrl

// ==== bench/pmsc_ctrl_assertions.sv ====
// Concurrent checks on the ports of the mode and status controller
module pmsc_ctrl_chk
    import pmsc_pkg::*;
(
    input logic        SYS_CLK,
    input logic        RST,
    input logic        CLK_EN,
    input logic        CYCLE_MONITOR_EXPIRED,
    input logic        HARD_FAULT,
    input logic [7:0]  DIGITAL_OUT_IN,
    input logic [7:0]  DIGITAL_OUT,
    input logic        RESUME_REQ,
    input pmsc_state_t STATE,
    input logic        RUN_INDICATOR,
    input logic        STOP_INDICATOR,
    input logic        HARD_STOP_INDICATOR,
    input logic        CYCLE_OVERRUN_INDICATOR,
    input logic        OUTPUT_INHIBIT_INDICATOR
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking pmsc_cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    sequence all_lamps_s;
        RUN_INDICATOR && STOP_INDICATOR && HARD_STOP_INDICATOR;
    endsequence
    sequence lamp_test_s;
        all_lamps_s [*8];
    endsequence
    lamp_test_a: assert property ($fell(RST) |=> lamp_test_s) else $error("lamp test missing");
    run_lamps_a: assert property (STATE == PMSC_ST_RUN |->
        RUN_INDICATOR && !STOP_INDICATOR && !HARD_STOP_INDICATOR) else $error("run lamps wrong");
    hard_lamps_a: assert property (STATE == PMSC_ST_HARD |->
        !RUN_INDICATOR && !STOP_INDICATOR && HARD_STOP_INDICATOR) else $error("hard stop lamps wrong");
    init_dark_a: assert property (STATE == PMSC_ST_INIT |->
        !(RUN_INDICATOR || STOP_INDICATOR || HARD_STOP_INDICATOR)) else $error("init lamps lit");
    hard_hold_a: assert property (STATE == PMSC_ST_HARD |=> STATE == PMSC_ST_HARD) else $error("hard stop left");
    inhibit_zero_a: assert property (OUTPUT_INHIBIT_INDICATOR |-> DIGITAL_OUT == 8'h00)
        else $error("outputs not safe");
    soft_inhibit_a: assert property (STATE == PMSC_ST_SOFT |-> OUTPUT_INHIBIT_INDICATOR)
        else $error("soft stop not inhibited");
    out_follow_a: assert property (STATE == PMSC_ST_RUN && $past(STATE) == PMSC_ST_RUN && $past(CLK_EN)
        |-> DIGITAL_OUT == $past(DIGITAL_OUT_IN)) else $error("outputs not following program");
    overrun_stop_a: assert property (CLK_EN && STATE == PMSC_ST_RUN && CYCLE_MONITOR_EXPIRED && !HARD_FAULT
        |=> STATE == PMSC_ST_SOFT && CYCLE_OVERRUN_INDICATOR) else $error("overrun not handled");
    resume_run_a: assert property (RESUME_REQ |-> STATE == PMSC_ST_RUN && !OUTPUT_INHIBIT_INDICATOR)
        else $error("restart not in run");
endmodule : pmsc_ctrl_chk
bind pmsc_ctrl pmsc_ctrl_chk pmsc_ctrl_chk_i (.SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(CLK_EN),
    .CYCLE_MONITOR_EXPIRED(CYCLE_MONITOR_EXPIRED), .HARD_FAULT(HARD_FAULT), .DIGITAL_OUT_IN(DIGITAL_OUT_IN),
    .DIGITAL_OUT(DIGITAL_OUT), .RESUME_REQ(RESUME_REQ), .STATE(STATE), .RUN_INDICATOR(RUN_INDICATOR),
    .STOP_INDICATOR(STOP_INDICATOR), .HARD_STOP_INDICATOR(HARD_STOP_INDICATOR),
    .CYCLE_OVERRUN_INDICATOR(CYCLE_OVERRUN_INDICATOR), .OUTPUT_INHIBIT_INDICATOR(OUTPUT_INHIBIT_INDICATOR));

// ==== bench/pmsc_panel.sv ====
// Operator model: momentary switch held around a bouncing mode-switch move
module pmsc_panel
    import pmsc_pkg::*;
(
    input  logic     clk,
    input  logic     go,
    input  logic     want_run,
    input  pmsc_mc_t want_mc,
    output logic     mode_sw,
    output logic     up_sw,
    output logic     down_sw,
    output logic     busy
);
    timeunit 1ns;
    timeprecision 100ps;
    pmsc_mc_t mc_r   = PMSC_MC_MID;
    int       cnt    = 0;
    logic     mode_r = 1'b0;
    logic     busy_r = 1'b0;
    assign mode_sw = mode_r;
    assign busy    = busy_r;
    assign up_sw   = (mc_r == PMSC_MC_UP);
    assign down_sw = (mc_r == PMSC_MC_DOWN);
    // Momentary position set first and held long after the mode contact settles
    always @(negedge clk) begin
        if (go) begin
            mc_r <= want_mc;
            cnt <= 0;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            cnt <= cnt + 1;
            case (cnt)
                2, 4: mode_r <= want_run;
                3: mode_r <= !want_run;
                40: begin
                    mc_r <= PMSC_MC_MID;
                    busy_r <= 1'b0;
                end
                default: ;
            endcase
        end
    end
endmodule : pmsc_panel

// ==== bench/pmsc_ctrl_bench.sv ====
// Self-checking bench for the mode and status controller
module pmsc_ctrl_bench;
    import pmsc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0, rst = 1'b1, init_done = 1'b0, fault_clear = 1'b0, cyc = 1'b0, hard = 1'b0;
    logic        go = 1'b0, want_run = 1'b0, mode_sw, up_sw, down_sw, busy;
    logic        clk_en = 1'b1, os_req = 1'b0, err_in = 1'b0;
    logic [2:0]  flt = 3'h0;
    logic [7:0]  din = 8'h00, dout, d;
    logic        prun, sbe, ram_erase, img_clr, startup, resume, run_l, stop_l, hard_l, ack_l, addr_l, ovr_l, inh_l;
    logic [3:0]  exp_p;
    logic [3:0]  pulse_q[$];
    pmsc_mc_t    want_mc = PMSC_MC_MID;
    pmsc_state_t state;
    int          num_errors = 0, checks = 0, seed = 66, t;
    always #2.5 sys_clk = ~sys_clk;
    pmsc_ctrl #(.DEBOUNCE_CYC(4), .LAMP_TEST_CYC(10), .FAST_HALF_CYC(4), .SLOW_HALF_CYC(16)) pmsc_ctrl_i (
        .SYS_CLK(sys_clk), .RST(rst), .CLK_EN(clk_en), .MODE_RUN_SW(mode_sw), .MC_UP_SW(up_sw), .MC_DOWN_SW(down_sw),
        .OS_OVERALL_REQ(os_req), .ERROR_STOP(err_in), .HARD_FAULT(hard), .INIT_DONE(init_done), .MEM_CLEAR_DONE(1'b0),
        .MODULE_ACK_TIMEOUT(flt[0]), .USER_MEM_TIMEOUT(flt[1]), .ADDRESSING_ERROR(flt[2]),
        .CYCLE_MONITOR_EXPIRED(cyc), .FAULT_CLEAR(fault_clear), .DIGITAL_OUT_IN(din), .DIGITAL_OUT(dout),
        .PROGRAM_RUN(prun), .STOP_BLOCK_ENABLE(sbe), .RAM_ERASE_REQ(ram_erase), .IMAGE_CLEAR_REQ(img_clr),
        .STARTUP_BLOCK_CALL(startup), .RESUME_REQ(resume), .STATE(state), .RUN_INDICATOR(run_l),
        .STOP_INDICATOR(stop_l), .HARD_STOP_INDICATOR(hard_l), .ACK_TIMEOUT_INDICATOR(ack_l),
        .ADDRESSING_ERROR_INDICATOR(addr_l), .CYCLE_OVERRUN_INDICATOR(ovr_l), .OUTPUT_INHIBIT_INDICATOR(inh_l));
    pmsc_panel pmsc_panel_i (.clk(sys_clk), .go(go), .want_run(want_run), .want_mc(want_mc), .mode_sw(mode_sw),
        .up_sw(up_sw), .down_sw(down_sw), .busy(busy));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic move(input logic run, input pmsc_mc_t mc);
        int i;
        want_run <= run;
        want_mc <= mc;
        go <= 1'b1;
        @(negedge sys_clk);
        go <= 1'b0;
        @(negedge sys_clk);
        for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge sys_clk);
        if (i == 100) begin
            num_errors++;
            $display("[FAIL] %0t panel stuck", $time);
            print_verdict();
        end
    endtask : move
    task automatic toggles(input int n, output int cnt);
        logic last;
        cnt = 0;
        last = stop_l;
        repeat (n) begin
            @(negedge sys_clk);
            if (stop_l !== last) cnt++;
            last = stop_l;
        end
    endtask : toggles
    task automatic lamps(input logic [2:0] exp);
        check({5'h00, run_l, stop_l, hard_l}, {5'h00, exp}, "status lamps");
    endtask : lamps
    // Every start pulse is matched against the oldest expected one
    always @(negedge sys_clk) begin
        if (!rst && (ram_erase | img_clr | startup | resume)) begin
            exp_p = (pulse_q.size() > 0) ? pulse_q.pop_front() : 4'h0;
            check({4'h0, ram_erase, img_clr, startup, resume}, {4'h0, exp_p}, "start pulse");
        end
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(negedge sys_clk);
        lamps(3'h7);
        repeat (12) @(negedge sys_clk);
        check({5'h00, state}, {5'h00, PMSC_ST_INIT}, "init state");
        lamps(3'h0);
        init_done <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check({7'h00, inh_l}, 8'h01, "power-up inhibit");
        toggles(24, t);
        check({7'h00, t >= 4}, 8'h01, "fast flash");
        $display("power-up done");
        pulse_q.push_back(4'h8);
        move(1'b1, PMSC_MC_DOWN);
        toggles(24, t);
        check({6'h00, t == 0, stop_l}, 8'h03, "steady stop after erase");
        move(1'b0, PMSC_MC_MID);
        pulse_q.push_back(4'h6);
        move(1'b1, PMSC_MC_UP);
        check({5'h00, state}, {5'h00, PMSC_ST_RUN}, "reset to run");
        lamps(3'h4);
        check({7'h00, inh_l}, 8'h00, "inhibit after reset");
        check({6'h00, prun, sbe}, 8'h02, "program running");
        repeat (8) begin
            d = 8'($random(seed));
            din <= d;
            @(negedge sys_clk);
            check(dout, d, "outputs follow");
        end
        clk_en <= 1'b0;
        din <= ~d;
        @(negedge sys_clk);
        check(dout, d, "frozen by enable");
        clk_en <= 1'b1;
        @(negedge sys_clk);
        check(dout, ~d, "enable resumed");
        $display("startup done");
        for (int k = 0; k < 3; k++) begin
            flt <= 3'b001 << k;
            @(negedge sys_clk);
            flt <= 3'h0;
            fault_clear <= 1'b1;
            check({6'h00, ack_l, addr_l}, (k < 2) ? 8'h02 : 8'h01, "fault lamp");
            @(negedge sys_clk);
            fault_clear <= 1'b0;
            @(negedge sys_clk);
            check({6'h00, ack_l, addr_l}, 8'h00, "fault clear");
        end
        flt <= 3'h4;
        fault_clear <= 1'b1;
        @(negedge sys_clk);
        flt <= 3'h0;
        check({7'h00, addr_l}, 8'h01, "set beats clear");
        @(negedge sys_clk);
        fault_clear <= 1'b0;
        move(1'b0, PMSC_MC_MID);
        check({5'h00, state}, {5'h00, PMSC_ST_SOFT}, "run to stop");
        lamps(3'h2);
        check({6'h00, prun, sbe}, 8'h01, "stop block enabled");
        check(dout, 8'h00, "outputs safe in stop");
        pulse_q.push_back(4'h1);
        move(1'b1, PMSC_MC_MID);
        lamps(3'h4);
        cyc <= 1'b1;
        @(negedge sys_clk);
        cyc <= 1'b0;
        check({5'h00, state}, {5'h00, PMSC_ST_SOFT}, "overrun stop");
        check({7'h00, ovr_l}, 8'h01, "overrun lamp");
        toggles(48, t);
        check({7'h00, t >= 2 && t <= 4}, 8'h01, "slow flash");
        move(1'b0, PMSC_MC_MID);
        pulse_q.push_back(4'h1);
        move(1'b1, PMSC_MC_MID);
        err_in <= 1'b1;
        @(negedge sys_clk);
        err_in <= 1'b0;
        check({5'h00, state}, {5'h00, PMSC_ST_SOFT}, "error stop");
        toggles(48, t);
        check({7'h00, t >= 2 && t <= 4}, 8'h01, "error slow flash");
        os_req <= 1'b1;
        @(negedge sys_clk);
        os_req <= 1'b0;
        toggles(24, t);
        check({7'h00, t >= 4}, 8'h01, "requested fast flash");
        move(1'b0, PMSC_MC_MID);
        move(1'b1, PMSC_MC_MID);
        check({5'h00, state}, {5'h00, PMSC_ST_SOFT}, "restart refused");
        $display("faults done");
        hard <= 1'b1;
        @(negedge sys_clk);
        hard <= 1'b0;
        lamps(3'h1);
        move(1'b0, PMSC_MC_UP);
        move(1'b1, PMSC_MC_UP);
        check({5'h00, state}, {5'h00, PMSC_ST_HARD}, "hard stop kept");
        check(8'(pulse_q.size()), 8'h00, "pulses missing");
        $display("hard stop done");
        print_verdict();
    end
endmodule : pmsc_ctrl_bench
